/* iapfm_pkg.sv */
// Shared constants, types and carriers for the flash command mailbox.
package iapfm_pkg;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_ADDR_HI = 8'h08;
	localparam logic [7:0] OFS_ADDR_LO = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CONFIG = 8'h14;
	// Field positions.
	localparam int CMD_IRQ_BIT = 7;
	localparam int CFG_EN_BIT = 6;
	localparam int CFG_SECOND_BIT = 1;
	localparam int CFG_BANK_BIT = 0;
	localparam int STS_BUSY_BIT = 2;
	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_CFG_EN = 1'b0;
	// Command codes, keys and selectors.
	localparam logic [6:0] CMD_CHIP_ERASE = 7'h01;
	localparam logic [6:0] CMD_BLOCK_ERASE = 7'h0d;
	localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0b;
	localparam logic [6:0] CMD_BYTE_PROG = 7'h0e;
	localparam logic [6:0] CMD_BYTE_VERIFY = 7'h0c;
	localparam logic [6:0] CMD_LOCK_ONE = 7'h0f;
	localparam logic [6:0] CMD_LOCK_TWO = 7'h03;
	localparam logic [6:0] CMD_LOCK_THREE = 7'h05;
	localparam logic [6:0] CMD_CONFIG = 7'h09;
	localparam logic [6:0] CMD_CLK_DOUBLE = 7'h08;
	localparam logic [7:0] KEY_ERASE = 8'h55;
	localparam logic [7:0] KEY_SET = 8'haa;
	localparam logic [7:0] SEL_CFG_FIRST = 8'h5a;
	localparam logic [7:0] SEL_CFG_SECOND = 8'haa;
	localparam logic [7:0] SEL_CLK_DOUBLE = 8'h55;
	localparam logic [2:0] SEC_BLOCK_SEL = 3'b111;
	localparam logic [15:0] SECTOR_BASE_MASK = 16'hff80;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Flash timing: core cycles per oscillator tick, then ticks per operation.
	localparam int DIV_CYC = 10;
	localparam int TIMER_W = 16;
	localparam int PROG_TICKS = 20;
	localparam int SECTOR_TICKS = 400;
	localparam int BLOCK_TICKS = 800;
	localparam int CHIP_TICKS = 1000;
	localparam int NV_BIT_TICKS = 20;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_VADDR = 2'b10,
		ST_VCAP = 2'b11
	} iapfm_state_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_CHIP_ERASE = 4'h1,
		OP_BLOCK_ERASE = 4'h2,
		OP_SECTOR_ERASE = 4'h3,
		OP_BYTE_PROG = 4'h4,
		OP_BYTE_READ = 4'h5,
		OP_LOCK_ONE = 4'h6,
		OP_LOCK_TWO = 4'h7,
		OP_LOCK_THREE = 4'h8,
		OP_CFG_FIRST = 4'h9,
		OP_CFG_SECOND = 4'ha,
		OP_CLK_DOUBLE = 4'hb
	} iapfm_op_t;

	typedef struct packed {
		iapfm_op_t op;
		logic blk;
		logic [15:0] addr;
		logic [7:0] wdata;
	} iapfm_flash_req_t;
endpackage

/* iapfm_op_timer.sv */
// Operation timer clocked by a divided oscillator tick.
`timescale 1ns/1ps
module iapfm_op_timer #(
	parameter int DIV = iapfm_pkg::DIV_CYC,
	parameter int W = iapfm_pkg::TIMER_W
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic load_i,
	input wire logic [W-1:0] ticks_i,
	output logic done_o
);
	logic run_r, run_nxt;
	logic [15:0] div_r, div_nxt;
	logic [W-1:0] cnt_r, cnt_nxt;
	logic done_nxt;
	logic tick;

	// The oscillator only runs while an operation is pending, as the real one would.
	always_comb begin
		tick = run_r && (div_r == 16'(DIV - 1));
		run_nxt = run_r;
		div_nxt = run_r ? (tick ? 16'h0000 : div_r + 16'h0001) : 16'h0000;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (load_i) begin
			run_nxt = 1'b1;
			div_nxt = 16'h0000;
			cnt_nxt = ticks_i;
		end else if (tick) begin
			if (cnt_r <= W'(1)) begin
				run_nxt = 1'b0;
				done_nxt = 1'b1;
			end
			cnt_nxt = cnt_r - W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_r <= 1'b0;
			div_r <= 16'h0000;
			cnt_r <= '0;
			done_o <= 1'b0;
		end else begin
			run_r <= run_nxt;
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			done_o <= done_nxt;
		end
	end
endmodule

/* iapfm_mailbox.sv */
// Flash command mailbox: AXI4-Lite registers and the command sequencer.
`timescale 1ns/1ps
module iapfm_mailbox #(
	parameter int PROG_TICKS = iapfm_pkg::PROG_TICKS,
	parameter int SECTOR_TICKS = iapfm_pkg::SECTOR_TICKS,
	parameter int BLOCK_TICKS = iapfm_pkg::BLOCK_TICKS,
	parameter int CHIP_TICKS = iapfm_pkg::CHIP_TICKS,
	parameter int NV_BIT_TICKS = iapfm_pkg::NV_BIT_TICKS
) (
	// Clock and reset.
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// AXI4-Lite slave.
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	output logic [1:0] AXI_BRESP_O,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	input wire logic [7:0] AXI_ARADDR_I,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	// Pins and stored nonvolatile bits; the disable pin and stored bits are sampled during reset, the other two pins are used live.
	input wire logic PROG_DISABLE_PIN_N_I,
	input wire logic EXTERNAL_ACCESS_PIN_N_I,
	input wire logic EXT_IRQ_ONE_PIN_N_I,
	input wire logic [2:0] NV_LOCK_I,
	input wire logic [1:0] NV_CONFIG_I,
	input wire logic NV_CLK_DOUBLE_I,
	// Flash array port.
	output logic FLASH_STB_O,
	output iapfm_pkg::iapfm_flash_req_t FLASH_REQ_O,
	input wire logic [7:0] FLASH_RDATA_I,
	// Core side.
	input wire logic CODE_READ_REQ_I,
	input wire logic CODE_READ_BLK_I,
	output logic CODE_READ_FAIL_O,
	output logic EXT_IRQ_ONE_O,
	output logic EXT_IRQ_PIN_GPIO_O,
	output logic CLK_DOUBLE_O,
	output logic [2:0] LOCK_BITS_O,
	output logic [1:0] CONFIG_BITS_O
);
	iapfm_pkg::iapfm_state_t st_r, st_nxt;
	iapfm_pkg::iapfm_flash_req_t req_r, req_nxt;
	iapfm_pkg::iapfm_op_t op;
	logic awready_r, awready_nxt, wready_r, wready_nxt, aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
	logic wstrb_r, wstrb_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] cmd_r, cmd_nxt, data_r, data_nxt, ahi_r, ahi_nxt, alo_r, alo_nxt;
	logic cfg_en_r, cfg_en_nxt, busy_r, busy_nxt, stb_r, stb_nxt, irq_r, irq_nxt, fail_r, fail_nxt;
	logic gpio_r, gpio_nxt, clkdbl_r, clkdbl_nxt;
	logic [2:0] lock_r, lock_nxt;
	logic [1:0] nvcfg_r, nvcfg_nxt;
	logic bank_sel_r, cfg_second_r, iap_dis_r;
	logic wr_go, mapped_wr, cmd_wr, accept, valid, tgt_sec, addr_ok, blk_locked, tmr_load, tmr_done;
	logic [15:0] ticks;

	iapfm_op_timer #(
		.DIV(iapfm_pkg::DIV_CYC),
		.W(16)
	) i_iapfm_op_timer (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.load_i(tmr_load),
		.ticks_i(ticks),
		.done_o(tmr_done)
	);

	// Command decode against the held address and data.
	always_comb begin
		tgt_sec = (ahi_r[7:5] == iapfm_pkg::SEC_BLOCK_SEL);
		addr_ok = !ahi_r[7] || tgt_sec;
		blk_locked = tgt_sec ? lock_r[2] : lock_r[1];
		op = iapfm_pkg::OP_NONE;
		valid = 1'b0;
		ticks = 16'(NV_BIT_TICKS);
		case (wdata_r[6:0])
			iapfm_pkg::CMD_CHIP_ERASE: begin
				op = iapfm_pkg::OP_CHIP_ERASE;
				valid = (data_r == iapfm_pkg::KEY_ERASE) && !EXTERNAL_ACCESS_PIN_N_I && !(&lock_r);
				ticks = 16'(CHIP_TICKS);
			end
			iapfm_pkg::CMD_BLOCK_ERASE: begin
				op = iapfm_pkg::OP_BLOCK_ERASE;
				valid = (data_r == iapfm_pkg::KEY_ERASE) && addr_ok && !blk_locked;
				ticks = 16'(BLOCK_TICKS);
			end
			iapfm_pkg::CMD_SECTOR_ERASE: begin
				op = iapfm_pkg::OP_SECTOR_ERASE;
				valid = addr_ok && !blk_locked;
				ticks = 16'(SECTOR_TICKS);
			end
			iapfm_pkg::CMD_BYTE_PROG: begin
				op = iapfm_pkg::OP_BYTE_PROG;
				valid = addr_ok && !blk_locked;
				ticks = 16'(PROG_TICKS);
			end
			iapfm_pkg::CMD_BYTE_VERIFY: begin
				op = iapfm_pkg::OP_BYTE_READ;
				valid = addr_ok && !blk_locked;
			end
			iapfm_pkg::CMD_LOCK_ONE: begin
				op = iapfm_pkg::OP_LOCK_ONE;
				valid = (data_r == iapfm_pkg::KEY_SET);
			end
			iapfm_pkg::CMD_LOCK_TWO: begin
				op = iapfm_pkg::OP_LOCK_TWO;
				valid = (data_r == iapfm_pkg::KEY_SET);
			end
			iapfm_pkg::CMD_LOCK_THREE: begin
				op = iapfm_pkg::OP_LOCK_THREE;
				valid = (data_r == iapfm_pkg::KEY_SET);
			end
			iapfm_pkg::CMD_CONFIG: begin
				op = (ahi_r == iapfm_pkg::SEL_CFG_FIRST) ? iapfm_pkg::OP_CFG_FIRST : iapfm_pkg::OP_CFG_SECOND;
				valid = (data_r == iapfm_pkg::KEY_SET) && ((ahi_r == iapfm_pkg::SEL_CFG_FIRST) ||
					(ahi_r == iapfm_pkg::SEL_CFG_SECOND));
			end
			iapfm_pkg::CMD_CLK_DOUBLE: begin
				op = iapfm_pkg::OP_CLK_DOUBLE;
				valid = (data_r == iapfm_pkg::KEY_SET) && (ahi_r == iapfm_pkg::SEL_CLK_DOUBLE);
			end
			default: begin
				valid = 1'b0;
			end
		endcase
	end

	// Bus slave and sequencer next state.
	always_comb begin
		awready_nxt = awready_r;
		wready_nxt = wready_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		st_nxt = st_r;
		req_nxt = req_r;
		cmd_nxt = cmd_r;
		data_nxt = data_r;
		ahi_nxt = ahi_r;
		alo_nxt = alo_r;
		cfg_en_nxt = cfg_en_r;
		busy_nxt = busy_r;
		stb_nxt = 1'b0;
		lock_nxt = lock_r;
		nvcfg_nxt = nvcfg_r;
		clkdbl_nxt = clkdbl_r;
		tmr_load = 1'b0;
		if (AXI_AWVALID_I && awready_r) begin
			awready_nxt = 1'b0;
			aw_have_nxt = 1'b1;
			awaddr_nxt = AXI_AWADDR_I;
		end
		if (AXI_WVALID_I && wready_r) begin
			wready_nxt = 1'b0;
			w_have_nxt = 1'b1;
			wdata_nxt = AXI_WDATA_I[7:0];
			wstrb_nxt = AXI_WSTRB_I[0];
		end
		wr_go = aw_have_r && w_have_r && !bvalid_r;
		mapped_wr = (awaddr_r == iapfm_pkg::OFS_CMD) || (awaddr_r == iapfm_pkg::OFS_DATA) ||
			(awaddr_r == iapfm_pkg::OFS_ADDR_HI) || (awaddr_r == iapfm_pkg::OFS_ADDR_LO) ||
			(awaddr_r == iapfm_pkg::OFS_STATUS) || (awaddr_r == iapfm_pkg::OFS_CONFIG);
		cmd_wr = wr_go && wstrb_r && (awaddr_r == iapfm_pkg::OFS_CMD);
		accept = cmd_wr && (st_r == iapfm_pkg::ST_IDLE) && cfg_en_r && !iap_dis_r;
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped_wr ? iapfm_pkg::RESP_OKAY : iapfm_pkg::RESP_SLVERR;
			if (wstrb_r) begin
				case (awaddr_r)
					iapfm_pkg::OFS_DATA: data_nxt = wdata_r;
					iapfm_pkg::OFS_ADDR_HI: ahi_nxt = wdata_r;
					iapfm_pkg::OFS_ADDR_LO: alo_nxt = wdata_r;
					iapfm_pkg::OFS_CONFIG: cfg_en_nxt = wdata_r[iapfm_pkg::CFG_EN_BIT];
					default: cfg_en_nxt = cfg_en_r;
				endcase
			end
		end
		if (bvalid_r && AXI_BREADY_I) begin
			bvalid_nxt = 1'b0;
			awready_nxt = 1'b1;
			wready_nxt = 1'b1;
		end
		if (AXI_ARVALID_I && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rresp_nxt = iapfm_pkg::RESP_OKAY;
			case (AXI_ARADDR_I)
				iapfm_pkg::OFS_CMD: rdata_nxt = {24'h000000, cmd_r};
				iapfm_pkg::OFS_DATA: rdata_nxt = {24'h000000, data_r};
				iapfm_pkg::OFS_ADDR_HI: rdata_nxt = {24'h000000, ahi_r};
				iapfm_pkg::OFS_ADDR_LO: rdata_nxt = {24'h000000, alo_r};
				iapfm_pkg::OFS_STATUS: rdata_nxt = 32'(busy_r) << iapfm_pkg::STS_BUSY_BIT;
				iapfm_pkg::OFS_CONFIG: rdata_nxt = (32'(cfg_en_r) << iapfm_pkg::CFG_EN_BIT) |
					(32'(cfg_second_r) << iapfm_pkg::CFG_SECOND_BIT) | (32'(bank_sel_r) << iapfm_pkg::CFG_BANK_BIT);
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = iapfm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_r && AXI_RREADY_I) begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
		case (st_r)
			iapfm_pkg::ST_IDLE: begin
				if (accept) begin
					cmd_nxt = wdata_r;
					if (valid) begin
						stb_nxt = 1'b1;
						req_nxt.op = op;
						req_nxt.blk = tgt_sec;
						req_nxt.wdata = data_r;
						req_nxt.addr = (op == iapfm_pkg::OP_SECTOR_ERASE) ?
							({ahi_r, alo_r} & iapfm_pkg::SECTOR_BASE_MASK) : {ahi_r, alo_r};
						if (op == iapfm_pkg::OP_BYTE_READ) begin
							st_nxt = iapfm_pkg::ST_VADDR;
						end else begin
							st_nxt = iapfm_pkg::ST_RUN;
							busy_nxt = 1'b1;
							tmr_load = 1'b1;
						end
					end
				end
			end
			iapfm_pkg::ST_RUN: begin
				if (tmr_done) begin
					st_nxt = iapfm_pkg::ST_IDLE;
					busy_nxt = 1'b0;
					case (req_r.op)
						iapfm_pkg::OP_LOCK_ONE: lock_nxt = lock_r | 3'b001;
						iapfm_pkg::OP_LOCK_TWO: lock_nxt = lock_r | 3'b010;
						iapfm_pkg::OP_LOCK_THREE: lock_nxt = lock_r | 3'b100;
						iapfm_pkg::OP_CFG_FIRST: nvcfg_nxt = nvcfg_r | 2'b01;
						iapfm_pkg::OP_CFG_SECOND: nvcfg_nxt = nvcfg_r | 2'b10;
						iapfm_pkg::OP_CLK_DOUBLE: clkdbl_nxt = 1'b1;
						iapfm_pkg::OP_CHIP_ERASE: begin
							lock_nxt = 3'b000;
							nvcfg_nxt = 2'b00;
						end
						default: lock_nxt = lock_r;
					endcase
				end
			end
			iapfm_pkg::ST_VADDR: begin
				st_nxt = iapfm_pkg::ST_VCAP;
			end
			iapfm_pkg::ST_VCAP: begin
				data_nxt = FLASH_RDATA_I;
				st_nxt = iapfm_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = iapfm_pkg::ST_IDLE;
			end
		endcase
		// The pin keeps its interrupt role only while interrupt completion is not selected.
		gpio_nxt = cfg_en_r && cmd_r[iapfm_pkg::CMD_IRQ_BIT];
		irq_nxt = gpio_r ? ((st_r == iapfm_pkg::ST_RUN) && tmr_done) : !EXT_IRQ_ONE_PIN_N_I;
		fail_nxt = CODE_READ_REQ_I && busy_r &&
			((req_r.op == iapfm_pkg::OP_CHIP_ERASE) || (CODE_READ_BLK_I == req_r.blk));
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= iapfm_pkg::RST_BYTE;
			wdata_r <= iapfm_pkg::RST_BYTE;
			wstrb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= iapfm_pkg::RESP_OKAY;
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= iapfm_pkg::RESP_OKAY;
			rdata_r <= 32'h00000000;
			st_r <= iapfm_pkg::ST_IDLE;
			req_r <= '0;
			cmd_r <= iapfm_pkg::RST_BYTE;
			data_r <= iapfm_pkg::RST_BYTE;
			ahi_r <= iapfm_pkg::RST_BYTE;
			alo_r <= iapfm_pkg::RST_BYTE;
			cfg_en_r <= iapfm_pkg::RST_CFG_EN;
			busy_r <= 1'b0;
			stb_r <= 1'b0;
			irq_r <= 1'b0;
			fail_r <= 1'b0;
			gpio_r <= 1'b0;
		end else begin
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			st_r <= st_nxt;
			req_r <= req_nxt;
			cmd_r <= cmd_nxt;
			data_r <= data_nxt;
			ahi_r <= ahi_nxt;
			alo_r <= alo_nxt;
			cfg_en_r <= cfg_en_nxt;
			busy_r <= busy_nxt;
			stb_r <= stb_nxt;
			irq_r <= irq_nxt;
			fail_r <= fail_nxt;
			gpio_r <= gpio_nxt;
		end
	end

	// Straps and stored bits are caught while reset is held; the active bank view stays frozen until then.
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			iap_dis_r <= !PROG_DISABLE_PIN_N_I;
			bank_sel_r <= NV_CONFIG_I[0];
			cfg_second_r <= NV_CONFIG_I[1];
			lock_r <= NV_LOCK_I;
			nvcfg_r <= NV_CONFIG_I;
			clkdbl_r <= NV_CLK_DOUBLE_I;
		end else begin
			lock_r <= lock_nxt;
			nvcfg_r <= nvcfg_nxt;
			clkdbl_r <= clkdbl_nxt;
		end
	end

	assign AXI_AWREADY_O = awready_r;
	assign AXI_WREADY_O = wready_r;
	assign AXI_BVALID_O = bvalid_r;
	assign AXI_BRESP_O = bresp_r;
	assign AXI_ARREADY_O = arready_r;
	assign AXI_RVALID_O = rvalid_r;
	assign AXI_RDATA_O = rdata_r;
	assign AXI_RRESP_O = rresp_r;
	assign FLASH_STB_O = stb_r;
	assign FLASH_REQ_O = req_r;
	assign CODE_READ_FAIL_O = fail_r;
	assign EXT_IRQ_ONE_O = irq_r;
	assign EXT_IRQ_PIN_GPIO_O = gpio_r;
	assign CLK_DOUBLE_O = clkdbl_r;
	assign LOCK_BITS_O = lock_r;
	assign CONFIG_BITS_O = nvcfg_r;

	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	chk_disabled_ignore: assert property (cmd_wr && !cfg_en_r && st_r == iapfm_pkg::ST_IDLE |=> !busy_r && !stb_r && $stable(cmd_r))
		else $error("command taken while enable bit clear");
	chk_pin_disable: assert property (iap_dis_r && cmd_wr |=> !stb_r && !busy_r)
		else $error("command taken while disable pin strap active");
	chk_irq_complete: assert property (st_r == iapfm_pkg::ST_RUN && tmr_done && gpio_r |=> EXT_IRQ_ONE_O && !busy_r)
		else $error("completion interrupt missing");
	chk_busy_start: assert property (accept && valid && op != iapfm_pkg::OP_BYTE_READ |=> busy_r ##1 busy_r)
		else $error("busy flag not raised at start");
	chk_verify_data: assert property (st_r == iapfm_pkg::ST_VCAP |=> data_r == $past(FLASH_RDATA_I) && !busy_r && !EXT_IRQ_ONE_O)
		else $error("verify data not captured");
	chk_lock_monotone: assert property (!(st_r == iapfm_pkg::ST_RUN && tmr_done && req_r.op == iapfm_pkg::OP_CHIP_ERASE)
		|=> (lock_r & $past(lock_r)) == $past(lock_r))
		else $error("lock bit returned to unprogrammed");
	chk_bank_frozen: assert property ($stable(bank_sel_r) && $stable(cfg_second_r))
		else $error("bank selection changed outside reset");
	chk_busy_ignore: assert property (cmd_wr && busy_r |=> $stable(cmd_r) && !stb_r)
		else $error("command taken while busy");
	chk_code_fail: assert property (CODE_READ_REQ_I && busy_r && CODE_READ_BLK_I == req_r.blk |=> CODE_READ_FAIL_O)
		else $error("code read to busy block did not fail");
	chk_chip_guard: assert property (accept && wdata_r[6:0] == iapfm_pkg::CMD_CHIP_ERASE && EXTERNAL_ACCESS_PIN_N_I
		|=> !stb_r)
		else $error("chip erase ran from internal memory");

	cov_chip_erase: cover property (st_r == iapfm_pkg::ST_RUN && tmr_done && req_r.op == iapfm_pkg::OP_CHIP_ERASE);
	cov_verify: cover property (st_r == iapfm_pkg::ST_VADDR ##1 st_r == iapfm_pkg::ST_VCAP);
	cov_irq: cover property (gpio_r && EXT_IRQ_ONE_O);
endmodule

/* tb_iapfm_mailbox.sv */
// Self-checking testbench for the flash command mailbox.
`timescale 1ns/1ps
module tb_iapfm_mailbox;
	logic clk, rst, awv, wv, br, arv, rr, dis_n, ea_n, crq, cblk, irq_pin_n, nv_cdbl;
	logic [3:0] wstrb;
	logic [7:0] awa, ara, frd, d, al;
	logic [31:0] wd, q;
	logic awr, wrd, bv, arr, rv, stb, fail, irq, gpio, cdbl;
	logic [1:0] bresp, rresp, cfg, nv_cfg;
	logic [31:0] rdata;
	logic [2:0] lock, nv_lock;
	iapfm_pkg::iapfm_flash_req_t req;
	logic [1:0] eb[$];
	logic [34:0] er[$];
	logic [27:0] fq[$];
	logic [34:0] e;
	logic [27:0] f;
	int err_count, n_tests, irq_n, seed;
	// Ticks are shortened so that every timed operation ends within a few dozen cycles.
	iapfm_mailbox #(.PROG_TICKS(2), .SECTOR_TICKS(3), .BLOCK_TICKS(4), .CHIP_TICKS(5), .NV_BIT_TICKS(2)) i_iapfm_mailbox (
		.CLK_I(clk), .SYS_RST_I(rst), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa),
		.AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_WDATA_I(wd), .AXI_WSTRB_I(wstrb), .AXI_BVALID_O(bv),
		.AXI_BREADY_I(br), .AXI_BRESP_O(bresp), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara),
		.AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
		.PROG_DISABLE_PIN_N_I(dis_n), .EXTERNAL_ACCESS_PIN_N_I(ea_n), .EXT_IRQ_ONE_PIN_N_I(irq_pin_n),
		.NV_LOCK_I(nv_lock), .NV_CONFIG_I(nv_cfg), .NV_CLK_DOUBLE_I(nv_cdbl), .FLASH_STB_O(stb), .FLASH_REQ_O(req),
		.FLASH_RDATA_I(frd), .CODE_READ_REQ_I(crq), .CODE_READ_BLK_I(cblk), .CODE_READ_FAIL_O(fail),
		.EXT_IRQ_ONE_O(irq), .EXT_IRQ_PIN_GPIO_O(gpio), .CLK_DOUBLE_O(cdbl), .LOCK_BITS_O(lock),
		.CONFIG_BITS_O(cfg));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task check(input string nm, input logic [33:0] s, input logic [33:0] x);
		n_tests++;
		if (s !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// The monitor takes the oldest note whenever a response or a flash strobe shows up.
	always @(posedge clk) begin
		if (bv && br) check("bresp", 34'(bresp), 34'(eb.pop_front()));
		if (rv && rr) begin
			e = er.pop_front();
			if (e[34]) check("rdata", {rresp, rdata}, e[33:0]);
		end
		if (stb) begin
			f = (fq.size() > 0) ? fq.pop_front() : 28'hfffffff;
			check("op", 34'(req.op), 34'(f[27:24]));
			if (f[27:24] == 4'h3 || f[27:24] == 4'h4) check("addr", 34'(req.addr), 34'(f[23:8]));
			if (f[27:24] == 4'h4) check("wdata", 34'(req.wdata), 34'(f[7:0]));
		end
		// The core side of the bench counts every interrupt as if the enables and edge mode were set.
		if (irq) irq_n++;
	end
	task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = iapfm_pkg::RESP_OKAY);
		@(posedge clk);
		eb.push_back(r);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= {24'h0, v};
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic c, input logic [31:0] x);
		@(posedge clk);
		er.push_back({c, 2'b00, x});
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		q = rdata;
		rr <= 1'b0;
	endtask
	task cmd(input logic [7:0] c, input logic [7:0] v, input logic [7:0] ah, input logic [7:0] lo);
		wr(iapfm_pkg::OFS_DATA, v);
		wr(iapfm_pkg::OFS_ADDR_HI, ah);
		wr(iapfm_pkg::OFS_ADDR_LO, lo);
		wr(iapfm_pkg::OFS_CMD, c);
	endtask
	task idle;
		int n;
		n = 0;
		do begin
			rd(iapfm_pkg::OFS_STATUS, 1'b0, 32'h0);
			n++;
		end while (q[2] && n < 100);
		check("idle", 34'(q[2]), 34'h0);
	endtask
	task do_reset;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		dis_n <= 1'b1;
	endtask
	initial begin
		#(30000 * 100);
		err_count++;
		end_of_test;
	end
	initial begin
		{awv, wv, br, arv, rr, crq, cblk} = '0;
		{awa, ara, wd, frd} = '0;
		{dis_n, ea_n, irq_pin_n} = 3'b111;
		{nv_lock, nv_cfg, nv_cdbl} = '0;
		wstrb = 4'hf;
		seed = 91198;
		rst = 1'b1;
		do_reset;
		rd(iapfm_pkg::OFS_CONFIG, 1'b1, 32'h0);
		wr(8'h30, 8'h01, iapfm_pkg::RESP_SLVERR);
		cmd(8'h0e, 8'h11, 8'h12, 8'h34);
		wr(iapfm_pkg::OFS_CONFIG, 8'h40);
		rd(iapfm_pkg::OFS_CONFIG, 1'b1, 32'h40);
		d = 8'($random(seed));
		fq.push_back({4'h4, 16'h1234, d});
		cmd(8'h0e, d, 8'h12, 8'h34);
		rd(iapfm_pkg::OFS_STATUS, 1'b1, 32'h4);
		@(posedge clk);
		crq <= 1'b1;
		@(posedge clk);
		crq <= 1'b0;
		@(posedge clk);
		check("code_fail", 34'(fail), 34'h1);
		wr(iapfm_pkg::OFS_CMD, 8'h0e);
		idle;
		rd(iapfm_pkg::OFS_STATUS, 1'b1, 32'h0);
		al = 8'($random(seed));
		fq.push_back({4'h3, 8'h12, al & 8'h80, 8'h0});
		cmd(8'h0b, 8'h0, 8'h12, al);
		idle;
		frd <= 8'($random(seed));
		fq.push_back({4'h5, 16'h1234, 8'h0});
		cmd(8'h8c, 8'h0, 8'h12, 8'h34);
		rd(iapfm_pkg::OFS_STATUS, 1'b1, 32'h0);
		rd(iapfm_pkg::OFS_DATA, 1'b1, {24'h0, frd});
		// A write whose low byte lane is off must leave the data register alone.
		wstrb <= 4'he;
		wr(iapfm_pkg::OFS_DATA, 8'h5a);
		wstrb <= 4'hf;
		rd(iapfm_pkg::OFS_DATA, 1'b1, {24'h0, frd});
		cmd(8'h7f, 8'h55, 8'h12, 8'h34);
		cmd(8'h0e, d, 8'h80, 8'h00);
		fq.push_back({4'h6, 24'h0});
		cmd(8'h8f, 8'haa, 8'h00, 8'h00);
		idle;
		check("lock", 34'(lock), 34'h1);
		check("gpio", 34'(gpio), 34'h1);
		fq.push_back({4'h7, 24'h0});
		cmd(8'h03, 8'haa, 8'h00, 8'h00);
		idle;
		check("lock", 34'(lock), 34'h3);
		cmd(8'h0e, d, 8'h12, 8'h34);
		fq.push_back({4'h4, 16'he034, d});
		cmd(8'h0e, d, 8'he0, 8'h34);
		idle;
		fq.push_back({4'h9, 24'h0});
		cmd(8'h09, 8'haa, 8'h5a, 8'h00);
		idle;
		check("config", 34'(cfg), 34'h1);
		rd(iapfm_pkg::OFS_CONFIG, 1'b1, 32'h40);
		fq.push_back({4'ha, 24'h0});
		cmd(8'h09, 8'haa, 8'haa, 8'h00);
		idle;
		check("config", 34'(cfg), 34'h3);
		rd(iapfm_pkg::OFS_CONFIG, 1'b1, 32'h40);
		fq.push_back({4'hb, 24'h0});
		cmd(8'h08, 8'haa, 8'h55, 8'h00);
		idle;
		check("clk_double", 34'(cdbl), 34'h1);
		cmd(8'h01, 8'h55, 8'h00, 8'h00);
		ea_n <= 1'b0;
		fq.push_back({4'h1, 24'h0});
		cmd(8'h01, 8'h55, 8'h00, 8'h00);
		idle;
		check("lock", 34'(lock), 34'h0);
		check("config", 34'(cfg), 34'h0);
		fq.push_back({4'h2, 24'h0});
		cmd(8'h0d, 8'h55, 8'he0, 8'h00);
		idle;
		fq.push_back({4'h8, 24'h0});
		cmd(8'h05, 8'haa, 8'h00, 8'h00);
		idle;
		check("lock", 34'(lock), 34'h4);
		// New stored bits are only picked up while reset is held.
		nv_lock <= 3'b001;
		nv_cfg <= 2'b11;
		dis_n <= 1'b0;
		do_reset;
		check("clk_double", 34'(cdbl), 34'h0);
		check("lock", 34'(lock), 34'h1);
		check("config", 34'(cfg), 34'h3);
		wr(iapfm_pkg::OFS_CONFIG, 8'h40);
		rd(iapfm_pkg::OFS_CONFIG, 1'b1, 32'h43);
		cmd(8'h0e, d, 8'h12, 8'h34);
		// Outside interrupt completion the pin still reaches the interrupt, one cycle late.
		irq_pin_n <= 1'b0;
		@(posedge clk);
		irq_pin_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("irq_count", 34'(irq_n), 34'h2);
		check("strobes_left", 34'(fq.size()), 34'h0);
		end_of_test;
	end
endmodule
